// *** otst_pkg.sv ***
// shared constants, codes and helpers for the option task sync trigger block
package otst_pkg;

	// clock and period timing
	localparam int CLK_PERIOD_NS  = 10;      // 100 MHz module clock
	localparam int BASE_PERIOD_NS = 250000;  // shortest position-task period, 250 us
	localparam int BASE_CYCLES    = (BASE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W          = 24;      // holds the 8 ms period count

	// register port shape
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int SEL_W  = 3;

	// register offsets
	localparam logic [ADDR_W-1:0] ADDR_PERIOD_SEL  = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_ROLE_SEL    = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_ROLE_STAT   = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_NET_MODE    = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_SCHED_FLAGS = 4'h4;

	// period select codes and reset value
	localparam logic [SEL_W-1:0] SEL_MIN   = 3'h1;
	localparam logic [SEL_W-1:0] SEL_MAX   = 3'h6;
	localparam logic [SEL_W-1:0] SEL_RESET = 3'h1;

	// role select codes
	localparam logic [DATA_W-1:0] ROLE_NONE     = 8'h00;
	localparam logic [DATA_W-1:0] ROLE_PRODUCER = 8'h01;
	localparam logic [DATA_W-1:0] ROLE_CONSUMER = 8'h02;

	// role status codes
	localparam logic [DATA_W-1:0] STAT_NONE     = 8'h00;
	localparam logic [DATA_W-1:0] STAT_SLOW     = 8'h02;
	localparam logic [DATA_W-1:0] STAT_PROD     = 8'h05;
	localparam logic [DATA_W-1:0] STAT_CONS     = 8'h06;
	localparam logic [DATA_W-1:0] STAT_PROD_NET = 8'h0d;

	// network sync mode codes
	localparam logic [DATA_W-1:0] NET_MODE_RESET = 8'h01;
	localparam logic [DATA_W-1:0] NET_MODE_SLAVE = 8'h1a;

	// slack allowed when comparing own period against the trigger interval
	localparam logic [CNT_W-1:0] LOCK_TOL = 24'h000004;

	// flag bit positions in the scheduler flag register
	localparam int FLAG_OVERRUN = 0;

	// task sequencer states
	typedef enum logic [3:0] {
		SEQ_IDLE    = 4'b0001,
		SEQ_FIRST   = 4'b0010,
		SEQ_PROFILE = 4'b0100,
		SEQ_SECOND  = 4'b1000
	} otst_seq_t;

	// period length in cycles: each select step doubles the base period
	function automatic logic [CNT_W-1:0] period_cycles(
		input logic [SEL_W-1:0] sel,
		input logic [CNT_W-1:0] base
	);
		logic [CNT_W-1:0] len;
		len = base;
		if (sel >= SEL_MIN && sel <= SEL_MAX)
		begin
			len = base << (sel - SEL_MIN);
		end
		return len;
	endfunction

endpackage

// *** otst_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/100ps
`default_nettype none
module otst_pin_sync (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic pin,
	output logic      level,
	output logic      rise
);
	logic s1_reg;      // first stage, read only by the second
	logic s2_reg;      // second stage
	logic s3_reg;      // third stage
	logic level_reg;   // filtered level
	logic level_next;

	// level moves only when stages two and three agree
	always_comb
	begin
		level_next = level_reg;
		if (s2_reg == s3_reg)
		begin
			level_next = s3_reg;
		end
	end

	// register the chain
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_reg    <= 1'b0;
			s2_reg    <= 1'b0;
			s3_reg    <= 1'b0;
			level_reg <= 1'b0;
		end
		else
		begin
			s1_reg    <= pin;
			s2_reg    <= s1_reg;
			s3_reg    <= s2_reg;
			level_reg <= level_next;
		end
	end

	assign level = level_reg;
	// one pulse per accepted low-to-high change
	assign rise  = level_next & ~level_reg;
endmodule
`default_nettype wire

// *** otst_period_timer.sv ***
// position-task period timer with realignment input
`timescale 1ns/100ps
`default_nettype none
module otst_period_timer #(
	parameter int CNT_W = 24
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             run,
	input  wire logic [CNT_W-1:0] len,
	input  wire logic             realign,
	output logic                  period_start
);
	logic [CNT_W-1:0] count_reg;   // cycles since the last boundary
	logic [CNT_W-1:0] count_next;
	logic             wrap;        // last cycle of the period

	// a realign restarts the period at once, which is how phase is pulled in
	always_comb
	begin
		wrap         = (count_reg >= len - 1'b1);
		period_start = run & (realign | wrap);
		if (!run || period_start)
		begin
			count_next = '0;
		end
		else
		begin
			count_next = count_reg + 1'b1;
		end
	end

	// register the count
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			count_reg <= '0;
		end
		else
		begin
			count_reg <= count_next;
		end
	end
endmodule
`default_nettype wire

// *** otst_top.sv ***
// inter-module position task sync: producer, consumer, status and task sequencer
//
// Function
// - producer fires trigger every position period
// - period select 1..6 gives 250us..8ms
// - consumer realigns its scheduler on trigger
// - consumer locks only if period not longer
// - slower consumer does not lock, status 2
// - role 1 producer, role 2 consumer
// - status 5 producer, 6 consumer, 13 network
// - network slave forces producer role
// - tasks run first, profile, second in order
// - only sequence start is phase aligned
`timescale 1ns/100ps
`default_nettype none
module otst_top #(
	parameter int BASE_CYCLES = otst_pkg::BASE_CYCLES
) (
	input  wire logic                        clk,
	input  wire logic                        rstn,
	input  wire logic [otst_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [otst_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [otst_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                        sync_trigger_in,
	output logic                             sync_trigger_out,
	input  wire logic                        network_sync_interrupt,
	input  wire logic                        task_done,
	output logic                             first_position_task,
	output logic                             profile_calc_task,
	output logic                             second_position_task
);
	localparam int CW = otst_pkg::CNT_W;
	localparam logic [CW-1:0] BASE_LEN = CW'(BASE_CYCLES);

	// software registers
	logic [otst_pkg::SEL_W-1:0]  period_sel_reg;   // position_period_select
	logic [otst_pkg::SEL_W-1:0]  period_sel_next;
	logic [otst_pkg::DATA_W-1:0] role_sel_reg;     // sync_role_select
	logic [otst_pkg::DATA_W-1:0] role_sel_next;
	logic [otst_pkg::DATA_W-1:0] net_mode_reg;     // network_sync_mode
	logic [otst_pkg::DATA_W-1:0] net_mode_next;
	logic [otst_pkg::DATA_W-1:0] role_stat_reg;    // sync_role_status, read only
	logic [otst_pkg::DATA_W-1:0] role_stat_next;
	logic                        overrun_reg;      // period came while tasks busy
	logic                        overrun_next;
	logic [otst_pkg::DATA_W-1:0] rdata_reg;
	logic [otst_pkg::DATA_W-1:0] rdata_next;

	// trigger interval measurement for consumers
	logic [CW-1:0] gap_cnt_reg;       // cycles since the last trigger
	logic [CW-1:0] gap_cnt_next;
	logic [CW-1:0] gap_reg;           // last measured trigger interval
	logic [CW-1:0] gap_next;
	logic          seen_reg;          // at least one trigger seen
	logic          seen_next;
	logic          gap_valid_reg;     // interval measured at least once
	logic          gap_valid_next;
	logic          net_locked_reg;    // aligned to the network interrupt
	logic          net_locked_next;
	logic          trig_out_reg;
	logic          trig_out_next;

	// sequencer
	otst_pkg::otst_seq_t seq_reg;
	otst_pkg::otst_seq_t seq_next;

	// decoded conditions
	logic          net_slave;         // module is a network sync slave
	logic          is_producer;
	logic          is_consumer;
	logic [CW-1:0] own_len;           // own period in cycles
	logic          len_ok;            // own period not longer than trigger period
	logic          can_lock;
	logic          realign;
	logic          period_start;
	logic          trig_rise;
	logic          net_rise;

	// peer trigger and network interrupt arrive from outside this clock
	otst_pin_sync u_trig_sync (
		.clk   (clk),
		.rstn  (rstn),
		.pin   (sync_trigger_in),
		.level (),
		.rise  (trig_rise)
	);

	otst_pin_sync u_net_sync (
		.clk   (clk),
		.rstn  (rstn),
		.pin   (network_sync_interrupt),
		.level (),
		.rise  (net_rise)
	);

	// role decode and lock decision
	always_comb
	begin
		net_slave   = (net_mode_reg == otst_pkg::NET_MODE_SLAVE);
		is_producer = (role_sel_reg == otst_pkg::ROLE_PRODUCER);
		is_consumer = (role_sel_reg == otst_pkg::ROLE_CONSUMER) && !net_slave;
		own_len     = otst_pkg::period_cycles(period_sel_reg, BASE_LEN);
		len_ok      = gap_valid_reg && (own_len <= gap_reg + otst_pkg::LOCK_TOL);
		can_lock    = is_consumer && len_ok;
		// consumer realigns; network slave producer follows the interrupt
		realign     = (can_lock && trig_rise) || (is_producer && net_slave && net_rise);
	end

	// period timer runs in every mode so tasks always get scheduled
	otst_period_timer #(
		.CNT_W (CW)
	) u_timer (
		.clk          (clk),
		.rstn         (rstn),
		.run          (1'b1),
		.len          (own_len),
		.realign      (realign),
		.period_start (period_start)
	);

	// register writes, status and read data
	always_comb
	begin
		period_sel_next = period_sel_reg;
		role_sel_next   = role_sel_reg;
		net_mode_next   = net_mode_reg;
		overrun_next    = overrun_reg;
		rdata_next      = '0;
		if (reg_wr)
		begin
			unique case (reg_addr)
				otst_pkg::ADDR_PERIOD_SEL:
				begin
					// out-of-range selects are ignored, keeping a valid period
					if (reg_wdata >= 8'(otst_pkg::SEL_MIN) && reg_wdata <= 8'(otst_pkg::SEL_MAX))
					begin
						period_sel_next = reg_wdata[otst_pkg::SEL_W-1:0];
					end
				end
				otst_pkg::ADDR_ROLE_SEL:    role_sel_next = reg_wdata;
				otst_pkg::ADDR_NET_MODE:    net_mode_next = reg_wdata;
				otst_pkg::ADDR_SCHED_FLAGS:
				begin
					// write one to clear
					if (reg_wdata[otst_pkg::FLAG_OVERRUN])
					begin
						overrun_next = 1'b0;
					end
				end
				default:
				begin
					// status and unmapped writes are dropped
				end
			endcase
		end
		if (net_slave)
		begin
			role_sel_next = otst_pkg::ROLE_PRODUCER;
		end
		// new period while tasks still run; set wins over clear
		if (period_start && seq_reg != otst_pkg::SEQ_IDLE)
		begin
			overrun_next = 1'b1;
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				otst_pkg::ADDR_PERIOD_SEL:  rdata_next = 8'(period_sel_reg);
				otst_pkg::ADDR_ROLE_SEL:    rdata_next = role_sel_reg;
				otst_pkg::ADDR_ROLE_STAT:   rdata_next = role_stat_reg;
				otst_pkg::ADDR_NET_MODE:    rdata_next = net_mode_reg;
				otst_pkg::ADDR_SCHED_FLAGS: rdata_next = 8'(overrun_reg);
				default:                    rdata_next = '0;
			endcase
		end
		role_stat_next = otst_pkg::STAT_NONE;
		if (is_producer && net_slave)
		begin
			role_stat_next = net_locked_reg ? otst_pkg::STAT_PROD_NET : otst_pkg::STAT_NONE;
		end
		else if (is_producer)
		begin
			role_stat_next = otst_pkg::STAT_PROD;
		end
		else if (is_consumer && gap_valid_reg)
		begin
			// too slow to know the producer phase
			role_stat_next = len_ok ? otst_pkg::STAT_CONS : otst_pkg::STAT_SLOW;
		end
	end

	// trigger interval measurement and producer output
	always_comb
	begin
		gap_cnt_next    = gap_cnt_reg;
		gap_next        = gap_reg;
		seen_next       = seen_reg;
		gap_valid_next  = gap_valid_reg;
		net_locked_next = net_locked_reg & is_producer & net_slave;
		if (is_producer && net_slave && net_rise)
		begin
			net_locked_next = 1'b1;
		end
		if (!is_consumer)
		begin
			// stale intervals must not decide a later lock
			gap_cnt_next   = '0;
			seen_next      = 1'b0;
			gap_valid_next = 1'b0;
		end
		else if (trig_rise)
		begin
			gap_cnt_next = '0;
			seen_next    = 1'b1;
			if (seen_reg)
			begin
				gap_next       = gap_cnt_reg + 1'b1;
				gap_valid_next = 1'b1;
			end
		end
		else if (gap_cnt_reg != {CW{1'b1}})
		begin
			gap_cnt_next = gap_cnt_reg + 1'b1;
		end
		trig_out_next = is_producer && period_start;
	end

	// register state of the control path
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			period_sel_reg <= otst_pkg::SEL_RESET;
			role_sel_reg   <= otst_pkg::ROLE_NONE;
			net_mode_reg   <= otst_pkg::NET_MODE_RESET;
			role_stat_reg  <= otst_pkg::STAT_NONE;
			overrun_reg    <= 1'b0;
			rdata_reg      <= '0;
			gap_cnt_reg    <= '0;
			gap_reg        <= '0;
			seen_reg       <= 1'b0;
			gap_valid_reg  <= 1'b0;
			net_locked_reg <= 1'b0;
			trig_out_reg   <= 1'b0;
		end
		else
		begin
			period_sel_reg <= period_sel_next;
			role_sel_reg   <= role_sel_next;
			net_mode_reg   <= net_mode_next;
			role_stat_reg  <= role_stat_next;
			overrun_reg    <= overrun_next;
			rdata_reg      <= rdata_next;
			gap_cnt_reg    <= gap_cnt_next;
			gap_reg        <= gap_next;
			seen_reg       <= seen_next;
			gap_valid_reg  <= gap_valid_next;
			net_locked_reg <= net_locked_next;
			trig_out_reg   <= trig_out_next;
		end
	end

	// task sequencer: only the start of the sequence is tied to the period
	always_comb
	begin
		seq_next = seq_reg;
		unique case (seq_reg)
			otst_pkg::SEQ_IDLE:
			begin
				if (period_start)
				begin
					seq_next = otst_pkg::SEQ_FIRST;
				end
			end
			// strict order, each step waits for its task to finish
			otst_pkg::SEQ_FIRST:   if (task_done) seq_next = otst_pkg::SEQ_PROFILE;
			otst_pkg::SEQ_PROFILE: if (task_done) seq_next = otst_pkg::SEQ_SECOND;
			otst_pkg::SEQ_SECOND:  if (task_done) seq_next = otst_pkg::SEQ_IDLE;
			default:               seq_next = otst_pkg::SEQ_IDLE;
		endcase
	end

	// register the sequencer
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			seq_reg <= otst_pkg::SEQ_IDLE;
		end
		else
		begin
			seq_reg <= seq_next;
		end
	end

	// read data and trigger straight from flops; task outputs decoded from the sequencer state
	assign reg_rdata            = rdata_reg;
	assign sync_trigger_out     = trig_out_reg;
	assign first_position_task  = (seq_reg == otst_pkg::SEQ_FIRST);
	assign profile_calc_task    = (seq_reg == otst_pkg::SEQ_PROFILE);
	assign second_position_task = (seq_reg == otst_pkg::SEQ_SECOND);

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence seq_first_ends;
		first_position_task && task_done;
	endsequence

	sequence seq_profile_ends;
		profile_calc_task && task_done;
	endsequence

	chk_trigger_on_boundary: assert property (
		is_producer && period_start && !reg_wr |=> sync_trigger_out)
		else $error("producer missed its period trigger");

	chk_period_decode: assert property (
		period_sel_reg == 3'h2 |-> own_len == (BASE_LEN << 1))
		else $error("period select 2 not decoded as twice the base");

	chk_consumer_realign: assert property (
		can_lock && trig_rise |-> period_start)
		else $error("consumer did not realign on trigger");

	chk_slow_no_lock: assert property (
		is_consumer && gap_valid_reg && !len_ok && trig_rise |-> !realign ##1 role_stat_reg == 8'h02)
		else $error("slow consumer locked or status not 2");

	chk_role_outputs: assert property (
		!is_producer |=> !sync_trigger_out)
		else $error("trigger driven while not producer");

	chk_status_codes: assert property (
		is_producer && !net_slave |=> role_stat_reg == 8'h05)
		else $error("producer status not 5");

	chk_force_producer: assert property (
		net_slave && reg_wr && reg_addr == otst_pkg::ADDR_ROLE_SEL |=> role_sel_reg == 8'h01)
		else $error("network slave role not forced to producer");

	chk_task_order: assert property (
		seq_first_ends |=> profile_calc_task && !first_position_task && !second_position_task)
		else $error("profile task did not follow first task");

	chk_second_follows: assert property (
		seq_profile_ends |=> second_position_task && !profile_calc_task)
		else $error("second task did not follow profile task");

	chk_sequence_start: assert property (
		period_start && seq_reg == otst_pkg::SEQ_IDLE |=> first_position_task)
		else $error("period boundary did not start the first task");

	chk_trigger_pulse: assert property (
		sync_trigger_out |=> !sync_trigger_out [*2])
		else $error("trigger wider than one cycle");
endmodule
`default_nettype wire

// *** otst_peer.sv ***
// peer option module model: drives the shared sync trigger as the producer
`timescale 1ns/100ps
`default_nettype none
module otst_peer (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        enable,
	input  wire logic [15:0] period,
	output logic             trig
);
	logic [15:0] cnt_reg; // cycles into the current peer period

	// sole driver, one pulse each period
	// the pulse is four cycles wide because the pin filter needs at least two
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn || !enable)
		begin
			cnt_reg <= 16'h0000;
			trig    <= 1'b0;
		end
		else
		begin
			cnt_reg <= (cnt_reg + 16'h0001 >= period) ? 16'h0000 : cnt_reg + 16'h0001;
			trig    <= (cnt_reg < 16'h0004);
		end
	end
endmodule
`default_nettype wire

// *** test_option_task_sync_trigger.sv ***
// self-checking bench for the option task sync trigger block
`timescale 1ns/100ps
`default_nettype none
module test_option_task_sync_trigger;
	localparam int BASE = 20; // shortened base period keeps the run short
	logic        clk, rstn, reg_wr, reg_rd;     // clock, reset, strobes
	logic [3:0]  reg_addr;                      // register index
	logic [7:0]  reg_wdata, reg_rdata;          // register data
	logic        trig_in, trig_out, net_irq;    // trigger link and interrupt
	logic        task_done, first_t, prof_t, second_t;
	logic        f_prev, p_prev, s_prev;        // task outputs one cycle back
	logic        peer_en, stall;                // peer enable, hold task_done low
	logic [15:0] peer_len;                      // peer period in cycles
	logic [31:0] seed;                          // xorshift state
	logic [1:0]  dly;                           // cycles before next task_done
	logic [2:0]  mon;                           // watched levels
	int          error_cnt, cmp_count, n, s;

	assign mon = {first_t, trig_in, trig_out};

	otst_top #(.BASE_CYCLES(BASE)) u_otst_top (.clk(clk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sync_trigger_in(trig_in), .sync_trigger_out(trig_out),
		.network_sync_interrupt(net_irq), .task_done(task_done),
		.first_position_task(first_t), .profile_calc_task(prof_t),
		.second_position_task(second_t));
	otst_peer u_otst_peer (.clk(clk), .rstn(rstn), .enable(peer_en), .period(peer_len),
		.trig(trig_in));

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// expected period length for a select code
	function automatic int exp_len(input int sel);
		return BASE << (sel - 1);
	endfunction

	task check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, e);
	endtask

	// bounded wait for a watched level; a spent bound ends the run
	task wait_sig(input int sel, input logic lvl, output int cnt);
		cnt = 0;
		do
		begin
			@(posedge clk);
			#1 cnt++;
		end
		while (mon[sel] !== lvl && cnt < 2000);
		if (cnt >= 2000)
		begin
			error_cnt++;
			give_verdict();
		end
	endtask

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// task completion after a random short delay, unless stalled
	always @(posedge clk)
	begin
		task_done <= 1'b0;
		if (!stall && (first_t || prof_t || second_t) && !task_done)
		begin
			if (dly == 2'h0)
			begin
				task_done <= 1'b1;
				seed = xs(seed);
				dly <= seed[1:0];
			end
			else
				dly <= dly - 2'h1;
		end
	end

	// each task may only start after its predecessor
	always @(posedge clk)
	begin
		if (rstn && prof_t && !p_prev)
			check(f_prev, 1'b1);
		if (rstn && second_t && !s_prev)
			check(p_prev, 1'b1);
		if (rstn && first_t && !f_prev)
			check(p_prev | s_prev, 1'b0);
		f_prev <= first_t;
		p_prev <= prof_t;
		s_prev <= second_t;
	end

	initial
	begin
		{rstn, reg_wr, reg_rd, reg_addr, reg_wdata, net_irq, task_done} = '0;
		{peer_en, stall, dly, f_prev, p_prev, s_prev} = '0;
		peer_len = 16'h0028;
		seed = 32'h00000020;
		error_cnt = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		check({trig_out, first_t, prof_t, second_t, reg_rdata}, 0);
		rstn <= 1'b1;
		// reset values, unmapped reads, read-only status
		rd(4'h0, 8'h01);
		rd(4'h1, 8'h00);
		rd(4'h2, 8'h00);
		rd(4'h3, 8'h01);
		rd(4'h4, 8'h00);
		rd(4'h9, 8'h00);
		wr(4'h2, 8'hff);
		rd(4'h2, 8'h00);
		$display("test reset done");
		// producer: trigger spacing for every select code
		wr(4'h1, 8'h01);
		for (s = 1; s <= 6; s++)
		begin
			wr(4'h0, s[7:0]);
			wait_sig(0, 1'b1, n);
			wait_sig(0, 1'b0, n);
			wait_sig(0, 1'b1, n);
			wait_sig(0, 1'b0, n);
			check(n, 1);
			wait_sig(0, 1'b1, n);
			check(n + 1, exp_len(s));
		end
		rd(4'h2, 8'h05);
		wr(4'h0, 8'h07);
		rd(4'h0, 8'h06);
		$display("test producer done");
		// network slave forces producer; interrupt restarts the period
		wr(4'h3, 8'h1a);
		wr(4'h1, 8'h02);
		rd(4'h1, 8'h01);
		rd(4'h2, 8'h00);
		wait_sig(0, 1'b1, n);
		repeat (100) @(posedge clk);
		net_irq <= 1'b1;
		wait_sig(0, 1'b1, n);
		check(n >= 3 && n <= 7, 1'b1);
		net_irq <= 1'b0;
		rd(4'h2, 8'h0d);
		wr(4'h3, 8'h01);
		$display("test network done");
		// consumer: shorter and equal periods lock, longer does not
		peer_en <= 1'b1;
		wr(4'h0, 8'h01);
		wr(4'h1, 8'h02);
		repeat (200) @(posedge clk);
		rd(4'h2, 8'h06);
		wr(4'h0, 8'h02);
		for (s = 0; s < 2; s++)
		begin
			repeat (200) @(posedge clk);
			rd(4'h2, 8'h06);
			wait_sig(1, 1'b0, n);
			wait_sig(1, 1'b1, n);
			wait_sig(2, 1'b1, n);
			check(n >= 3 && n <= 6, 1'b1);
			// shift the peer phase by a random gap
			peer_en <= 1'b0;
			seed = xs(seed);
			repeat (3 + seed[4:0]) @(posedge clk);
			peer_en <= 1'b1;
		end
		wr(4'h0, 8'h03);
		repeat (300) @(posedge clk);
		rd(4'h2, 8'h02);
		peer_en <= 1'b0;
		$display("test consumer done");
		// boundary during a running sequence sets overrun, cleared by one
		wr(4'h1, 8'h01);
		wr(4'h0, 8'h01);
		stall <= 1'b1;
		repeat (60) @(posedge clk);
		rd(4'h4, 8'h01);
		stall <= 1'b0;
		repeat (40) @(posedge clk);
		wr(4'h4, 8'h01);
		rd(4'h4, 8'h00);
		$display("test overrun done");
		give_verdict();
	end
endmodule
`default_nettype wire
